// file: design/acl_matching_rule_evaluator.sv
// Module: ACL matching table, processing select and count-mode interrupts
//
// Functional notes
// RULE1 - Rule mode 00 disables entry, never matches
// RULE2 - Rule mode selects L2, L3 or L4
// RULE3 - L2 select: type, MAC, or both
// RULE4 - L2 select 00: count mode, MAC+type
// RULE5 - Select bit: 0 destination, 1 source
// RULE6 - Equality sense sets match polarity
// RULE7 - Count value from action entry fields
// RULE8 - Time unit: microsecond or millisecond tick
// RULE9 - Countdown algorithm interrupts on inactivity expiry
// RULE10 - Count-up algorithm interrupts at terminal count
// RULE11 - L3 select: masked single, exact both
// RULE12 - Exact mode: mask field holds destination
// RULE13 - Mask bit 1 excludes address bit
// RULE14 - L4 select: protocol, TCP, UDP, sequence
// RULE15 - Port bounds joined form sequence number
// RULE16 - Port compare: off, either, in, out
// RULE17 - Protocol byte compared with entry value
// RULE18 - Flag match on unmasked bits when enabled
// RULE19 - Selected entries combine by AND
// RULE20 - Lowest first-rule pointer wins, one action
// RULE21 - Per-port count interrupts, status and mask
// RULE22 - Range bounds inclusive; select picks port
// RULE23 - Countdown reloads on each qualifying packet
`timescale 1ns/1ns
module acl_matching_rule_evaluator (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Table writes
  input wire logic matchWrEn,
  input wire logic actionWrEn,
  input wire logic procWrEn,
  input wire logic [3:0] tblIndex,
  input wire acl_pkg::match_entry_t matchWrData,
  input wire acl_pkg::action_entry_t actionWrData,
  input wire acl_pkg::proc_entry_t procWrData,
  // Parsed frame header
  input wire acl_pkg::frame_hdr_t hdr,
  // Result to action stage
  output acl_pkg::acl_result_t result,
  // Count-mode interrupts
  input wire logic [acl_pkg::NUM_PORTS-1:0] irqMask,
  input wire logic [acl_pkg::NUM_PORTS-1:0] irqClear,
  output logic [acl_pkg::NUM_PORTS-1:0] irqStatus,
  output logic [acl_pkg::NUM_PORTS-1:0] portIrq
);

  localparam int NE = acl_pkg::NUM_ENTRIES;
  localparam int CW = acl_pkg::COUNT_W;

  acl_pkg::match_entry_t matchTbl [NE];
  acl_pkg::action_entry_t actionTbl [NE];
  acl_pkg::proc_entry_t procTbl [NE];
  logic [NE-1:0] entryHit;
  logic [NE-1:0] procHit;
  logic [NE-1:0] fireVec;
  logic [2:0] firePort [NE];
  logic bestHit;
  logic [3:0] bestIdx;
  logic [acl_pkg::NUM_PORTS-1:0] setVec;
  logic [acl_pkg::NUM_PORTS-1:0] next_irqStatus;
  logic [4:0] usCnt;
  logic [9:0] msCnt;
  logic usTick;
  logic msTick;

  // ----------------------------------------
  // Single entry evaluation
  // ----------------------------------------
  function automatic logic evalEntry(input acl_pkg::match_entry_t m,
                                     input acl_pkg::frame_hdr_t h);
    logic [47:0] mac;
    logic [31:0] ip;
    logic [15:0] port;
    logic inRange;
    logic portOk;
    logic flagOk;
    logic raw;
    logic ok;
    mac = m.srcSelect ? h.srcMac : h.dstMac; // RULE5
    ip = m.srcSelect ? h.srcIp : h.dstIp;
    port = m.srcSelect ? h.srcPort : h.dstPort; // RULE22
    inRange = (port >= m.portLower) && (port <= m.portUpper); // RULE22
    case (m.portCompareMode) // RULE16
      acl_pkg::PC_EITHER: portOk = (port == m.portUpper) || (port == m.portLower);
      acl_pkg::PC_IN: portOk = inRange;
      acl_pkg::PC_OUT: portOk = !inRange;
      default: portOk = 1'b1;
    endcase
    flagOk = !m.tcpFlagMatchEnable
             || (((h.tcpFlags ^ m.tcpFlagValue) & ~m.tcpFlagMask) == 8'h00); // RULE18
    raw = 1'b0;
    ok = 1'b0;
    case (m.ruleMode) // RULE2
      acl_pkg::MODE_L2:
      begin
        ok = 1'b1;
        case (m.compareSelect) // RULE3
          acl_pkg::L2_TYPE: raw = (h.etherType == m.etherType);
          acl_pkg::L2_MAC: raw = (mac == m.macAddr);
          default: raw = (mac == m.macAddr) && (h.etherType == m.etherType); // RULE4
        endcase
      end
      acl_pkg::MODE_L3:
      begin
        case (m.compareSelect) // RULE11
          acl_pkg::L3_MASKED:
          begin
            ok = h.isIpv4;
            raw = ((ip ^ m.ipv4Addr) & ~m.ipv4BitMask) == 32'h0000_0000; // RULE13
          end
          acl_pkg::L3_EXACT:
          begin
            ok = h.isIpv4;
            raw = (h.srcIp == m.ipv4Addr) && (h.dstIp == m.ipv4BitMask); // RULE12
          end
          default: ok = 1'b0;
        endcase
      end
      acl_pkg::MODE_L4:
      begin
        case (m.compareSelect) // RULE14
          acl_pkg::L4_PROTO:
          begin
            ok = h.isIpv4;
            raw = (h.ipProtocol == m.ipProtocolValue); // RULE17
          end
          acl_pkg::L4_TCP:
          begin
            ok = h.isTcp;
            raw = portOk && flagOk;
          end
          acl_pkg::L4_UDP:
          begin
            ok = h.isUdp;
            raw = portOk;
          end
          default:
          begin
            ok = h.isTcp;
            raw = (h.tcpSeq == {m.portUpper, m.portLower}) && flagOk; // RULE15
          end
        endcase
      end
      default: ok = 1'b0; // RULE1
    endcase
    return ok && (m.equalitySense ? raw : !raw); // RULE6
  endfunction : evalEntry

  // ----------------------------------------
  // Table storage
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      for (int i = 0; i < NE; i++)
      begin
        matchTbl[i] <= '0;
        actionTbl[i] <= '0;
        procTbl[i] <= '0;
      end
    end
    else
    begin
      if (matchWrEn)
        matchTbl[tblIndex] <= matchWrData;
      if (actionWrEn)
        actionTbl[tblIndex] <= actionWrData;
      if (procWrEn)
        procTbl[tblIndex] <= procWrData;
    end
  end

  // ----------------------------------------
  // Tick dividers
  // ----------------------------------------
  assign msTick = usTick && (msCnt == 10'(acl_pkg::MS_US - 1));

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      usCnt <= 5'h00;
      usTick <= 1'b0;
      msCnt <= 10'h000;
    end
    else
    begin
      usTick <= (usCnt == 5'(acl_pkg::US_CYCLES - 1));
      usCnt <= (usCnt == 5'(acl_pkg::US_CYCLES - 1)) ? 5'h00 : usCnt + 5'h01;
      if (msTick)
        msCnt <= 10'h000;
      else if (usTick)
        msCnt <= msCnt + 10'h001;
    end
  end

  // ----------------------------------------
  // Per-entry match and counters
  // ----------------------------------------
  for (genvar i = 0; i < NE; i++)
  begin : g_entry
    acl_pkg::match_entry_t m;
    acl_pkg::action_entry_t a;
    logic countMode;
    logic countPkt;
    logic unitTick;
    logic cfgWr;
    logic [CW-1:0] countVal;
    logic [CW-1:0] cnt;
    logic [CW-1:0] cntUp;
    logic armed;
    logic fire;
    logic [2:0] lastPort;
    logic [2:0] firePortQ;

    assign m = matchTbl[i];
    assign a = actionTbl[i];
    assign entryHit[i] = hdr.valid && evalEntry(m, hdr);
    assign countMode = (m.ruleMode == acl_pkg::MODE_L2)
                       && (m.compareSelect == acl_pkg::L2_COUNT); // RULE4
    assign countPkt = countMode && entryHit[i];
    assign countVal = {a.priorityMode, a.priorityValue, a.remarkEnable,
                       a.remarkPriority, a.mapMode}; // RULE7
    assign unitTick = a.timeUnit ? msTick : usTick; // RULE8
    assign cntUp = cnt + 11'h001;
    assign cfgWr = (matchWrEn || actionWrEn) && (tblIndex == 4'(i));
    assign fireVec[i] = fire;
    assign firePort[i] = firePortQ;

    // Rewriting the entry drops any count in flight
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
      if (!rst_b)
      begin
        cnt <= acl_pkg::COUNT_RESET;
        armed <= 1'b0;
        fire <= 1'b0;
        lastPort <= 3'h0;
        firePortQ <= 3'h0;
      end
      else
      begin
        fire <= 1'b0;
        if (countPkt)
          lastPort <= hdr.ingressPort;
        if (!countMode || cfgWr)
        begin
          cnt <= acl_pkg::COUNT_RESET;
          armed <= 1'b0;
        end
        else if (a.counterAlgorithm)
        begin
          if (countPkt && (cntUp == countVal)) // RULE10
          begin
            cnt <= acl_pkg::COUNT_RESET;
            fire <= 1'b1;
            firePortQ <= hdr.ingressPort;
          end
          else if (countPkt)
            cnt <= cntUp;
        end
        else if (countPkt) // RULE23
        begin
          cnt <= countVal;
          armed <= 1'b1;
        end
        else if (armed && unitTick) // RULE9
        begin
          if (cnt <= 11'h001)
          begin
            armed <= 1'b0;
            fire <= 1'b1;
            firePortQ <= lastPort;
          end
          else
            cnt <= cnt - 11'h001;
        end
      end
    end
  end : g_entry

  // ----------------------------------------
  // Processing entries and action select
  // ----------------------------------------
  for (genvar p = 0; p < NE; p++)
  begin : g_proc
    logic [NE-1:0] sel;
    assign sel = procTbl[p].ruleSelectBitmap;
    assign procHit[p] = (sel != '0) && ((entryHit & sel) == sel); // RULE19
  end : g_proc

  always_comb
  begin
    bestHit = 1'b0;
    bestIdx = 4'h0;
    for (int p = 0; p < NE; p++)
    begin
      if (procHit[p] && (!bestHit || procTbl[p].firstRulePointer < bestIdx)) // RULE20
      begin
        bestHit = 1'b1;
        bestIdx = procTbl[p].firstRulePointer;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      result <= '0;
    else
    begin
      result.valid <= hdr.valid;
      result.hit <= bestHit;
      result.actionIndex <= bestIdx;
      result.action <= actionTbl[bestIdx];
      result.entryHits <= entryHit;
    end
  end

  // ----------------------------------------
  // Per-port interrupt status
  // ----------------------------------------
  // Plain filtering hits never reach here; only counter expiries do
  always_comb
  begin
    setVec = '0;
    for (int e = 0; e < NE; e++)
    begin
      if (fireVec[e] && (firePort[e] < 3'(acl_pkg::NUM_PORTS))) // RULE21
        setVec[firePort[e]] = 1'b1;
    end
  end

  // Set wins over a clear in the same cycle
  assign next_irqStatus = (irqStatus & ~irqClear) | setVec;

  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      irqStatus <= acl_pkg::IRQ_STATUS_RESET;
      portIrq <= acl_pkg::IRQ_STATUS_RESET;
    end
    else
    begin
      irqStatus <= next_irqStatus;
      portIrq <= next_irqStatus & irqMask; // RULE21
    end
  end

endmodule : acl_matching_rule_evaluator

// file: design/acl_pkg.sv
// Package: ACL matching table types, codes and timing constants
package acl_pkg;

  // ----------------------------------------
  // Sizes and timing
  // ----------------------------------------
  localparam int NUM_ENTRIES = 16;
  localparam int NUM_PORTS = 6;
  localparam int COUNT_W = 11;
  localparam int CLK_PERIOD_NS = 50;
  localparam int US_NS = 1000;
  localparam int US_CYCLES = (US_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MS_US = 1000;

  // ----------------------------------------
  // Field codes
  // ----------------------------------------
  localparam logic [1:0] MODE_OFF = 2'h0;
  localparam logic [1:0] MODE_L2 = 2'h1;
  localparam logic [1:0] MODE_L3 = 2'h2;
  localparam logic [1:0] MODE_L4 = 2'h3;
  localparam logic [1:0] L2_COUNT = 2'h0;
  localparam logic [1:0] L2_TYPE = 2'h1;
  localparam logic [1:0] L2_MAC = 2'h2;
  localparam logic [1:0] L3_MASKED = 2'h1;
  localparam logic [1:0] L3_EXACT = 2'h2;
  localparam logic [1:0] L4_PROTO = 2'h0;
  localparam logic [1:0] L4_TCP = 2'h1;
  localparam logic [1:0] L4_UDP = 2'h2;
  localparam logic [1:0] L4_SEQ = 2'h3;
  localparam logic [1:0] PC_EITHER = 2'h1;
  localparam logic [1:0] PC_IN = 2'h2;
  localparam logic [1:0] PC_OUT = 2'h3;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [NUM_PORTS-1:0] IRQ_STATUS_RESET = 6'h00;
  localparam logic [COUNT_W-1:0] COUNT_RESET = 11'h000;

  // ----------------------------------------
  // Table entries
  // ----------------------------------------
  typedef struct packed {
    logic [1:0] ruleMode;
    logic [1:0] compareSelect;
    logic srcSelect;
    logic equalitySense;
    logic [47:0] macAddr;
    logic [15:0] etherType;
    logic [31:0] ipv4Addr;
    logic [31:0] ipv4BitMask;
    logic [15:0] portUpper;
    logic [15:0] portLower;
    logic [1:0] portCompareMode;
    logic [7:0] ipProtocolValue;
    logic tcpFlagMatchEnable;
    logic [7:0] tcpFlagMask;
    logic [7:0] tcpFlagValue;
  } match_entry_t;

  typedef struct packed {
    logic [1:0] priorityMode;
    logic [2:0] priorityValue;
    logic remarkEnable;
    logic [2:0] remarkPriority;
    logic [1:0] mapMode;
    logic [NUM_PORTS-1:0] forwardMap;
    logic timeUnit;
    logic counterAlgorithm;
  } action_entry_t;

  typedef struct packed {
    logic [3:0] firstRulePointer;
    logic [NUM_ENTRIES-1:0] ruleSelectBitmap;
  } proc_entry_t;

  // ----------------------------------------
  // Frame header and result
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [2:0] ingressPort;
    logic [47:0] dstMac;
    logic [47:0] srcMac;
    logic [15:0] etherType;
    logic isIpv4;
    logic isTcp;
    logic isUdp;
    logic [31:0] srcIp;
    logic [31:0] dstIp;
    logic [7:0] ipProtocol;
    logic [15:0] srcPort;
    logic [15:0] dstPort;
    logic [31:0] tcpSeq;
    logic [7:0] tcpFlags;
  } frame_hdr_t;

  typedef struct packed {
    logic valid;
    logic hit;
    logic [3:0] actionIndex;
    action_entry_t action;
    logic [NUM_ENTRIES-1:0] entryHits;
  } acl_result_t;

endpackage : acl_pkg

// file: verification/acl_hdr_source.sv
// Partner model: ingress parser handing one header per request
`timescale 1ns/1ns
module acl_hdr_source (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Request from bench
  input wire logic sendReq,
  input wire acl_pkg::frame_hdr_t nextHdr,
  // Header to block
  output acl_pkg::frame_hdr_t hdr
);
  // Fields toggle between frames so stale values never pass for real ones
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
      hdr <= '0;
    else if (sendReq)
      hdr <= {1'b1, nextHdr[261:0]};
    else
      hdr <= {1'b0, ~hdr[261:0]};
  end
endmodule : acl_hdr_source

// file: verification/acl_matching_rule_evaluator_test.sv
// Testbench: entry matching, processing select and count-mode interrupts
`timescale 1ns/1ns
module acl_matching_rule_evaluator_test;
  logic clk_sys = 1'b0;
  logic rst_b = 1'b0;
  logic matchWrEn = 1'b0;
  logic actionWrEn = 1'b0;
  logic procWrEn = 1'b0;
  logic [3:0] tblIndex = 4'h0;
  acl_pkg::match_entry_t matchWrData = '0;
  acl_pkg::action_entry_t actionWrData = '0;
  acl_pkg::proc_entry_t procWrData = '0;
  logic sendReq = 1'b0;
  acl_pkg::frame_hdr_t nextHdr = '0;
  acl_pkg::frame_hdr_t hdr;
  acl_pkg::acl_result_t result;
  logic [5:0] irqMask = 6'h04;
  logic [5:0] irqClear = 6'h00;
  logic [5:0] irqStatus;
  logic [5:0] portIrq;
  logic [39:0] expQ[$];
  logic [39:0] expNow;
  acl_pkg::action_entry_t expAct = '0;
  acl_pkg::frame_hdr_t h;
  acl_pkg::match_entry_t m;
  acl_pkg::action_entry_t a;
  logic [287:0] r;
  int seed = 39;
  int failures = 0;
  int checkCount = 0;

  always #25 clk_sys = ~clk_sys;

  acl_hdr_source partner (.clk_sys(clk_sys), .rst_b(rst_b), .sendReq(sendReq),
    .nextHdr(nextHdr), .hdr(hdr));
  acl_matching_rule_evaluator DUT (.clk_sys(clk_sys), .rst_b(rst_b), .matchWrEn(matchWrEn),
    .actionWrEn(actionWrEn), .procWrEn(procWrEn), .tblIndex(tblIndex),
    .matchWrData(matchWrData), .actionWrData(actionWrData), .procWrData(procWrData),
    .hdr(hdr), .result(result), .irqMask(irqMask), .irqClear(irqClear),
    .irqStatus(irqStatus), .portIrq(portIrq));

  task automatic finish_test;
    if (failures == 0 && checkCount > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  task automatic check(input string nm, input logic [20:0] seen, input logic [20:0] ex);
    checkCount++;
    if (seen !== ex)
    begin
      failures++;
      $display("Error %s expected %h seen %h", nm, ex, seen);
    end
  endtask : check

  task automatic wr(input logic [3:0] ix, input acl_pkg::match_entry_t me,
    input acl_pkg::action_entry_t ae, input acl_pkg::proc_entry_t pe, input logic [2:0] en);
    tblIndex <= ix;
    matchWrData <= me;
    actionWrData <= ae;
    procWrData <= pe;
    {matchWrEn, actionWrEn, procWrEn} <= en;
    @(posedge clk_sys);
    {matchWrEn, actionWrEn, procWrEn} <= 3'h0;
    @(posedge clk_sys);
  endtask : wr

  task automatic send(input acl_pkg::frame_hdr_t hv, input logic [20:0] ex);
    expQ.push_back({expAct, ex});
    nextHdr <= hv;
    sendReq <= 1'b1;
    @(posedge clk_sys);
    sendReq <= 1'b0;
    @(posedge clk_sys);
  endtask : send

  // Single-entry case on entry 0, selected alone by processing entry 0
  task automatic tc(input acl_pkg::match_entry_t me, input logic e);
    wr(4'h0, me, '0, 20'h00001, 3'h4);
    send(h, {15'h0, e, e, 4'h0});
  endtask : tc

  task automatic waitIrq(input int b, input int lo, input int hi);
    int n;
    n = 0;
    while (irqStatus[b] !== 1'b1 && n < hi)
    begin
      @(posedge clk_sys);
      n++;
    end
    check("irqDelay", 21'(n >= lo), 21'h1);
    if (n >= hi)
    begin
      failures++;
      finish_test();
    end
  endtask : waitIrq

  task automatic clr(input logic [5:0] bits);
    irqClear <= bits;
    @(posedge clk_sys);
    irqClear <= 6'h00;
    repeat (2) @(posedge clk_sys);
    check("irqClear", 21'(irqStatus & bits), 21'h0);
  endtask : clr

  always @(posedge clk_sys)
  begin
    if (result.valid === 1'b1)
    begin
      expNow = (expQ.size() > 0) ? expQ.pop_front() : 40'hFF_FFFF_FFFF;
      check("result", {result.entryHits, result.hit, result.actionIndex},
        expNow[20:0]);
      check("action", 21'(result.action), 21'(expNow[39:21]));
    end
  end

  initial
  begin
    repeat (9) r = {r[255:0], 32'($random(seed))};
    h = r[262:0];
    h.ingressPort = 3'h2;
    h.srcMac = ~h.dstMac;
    h.isIpv4 = 1'b1;
    h.isTcp = 1'b1;
    h.isUdp = 1'b0;
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    wr(4'h0, '0, '0, 20'h00001, 3'h1);
    m = '0;
    tc(m, 1'b0);
    m.ruleMode = acl_pkg::MODE_L2;
    m.equalitySense = 1'b1;
    m.macAddr = h.srcMac;
    m.etherType = h.etherType;
    for (int cs = 1; cs < 4; cs++)
    begin
      m.compareSelect = 2'(cs);
      tc(m, cs == 1);
    end
    m.srcSelect = 1'b1;
    tc(m, 1'b1);
    m.equalitySense = 1'b0;
    tc(m, 1'b0);
    m.etherType = ~h.etherType;
    tc(m, 1'b1);
    m.ruleMode = acl_pkg::MODE_L3;
    m.compareSelect = acl_pkg::L3_MASKED;
    m.srcSelect = 1'b0;
    m.equalitySense = 1'b1;
    m.ipv4Addr = h.dstIp ^ 32'h000000F0;
    m.ipv4BitMask = 32'h000000F0;
    tc(m, 1'b1);
    m.ipv4BitMask = 32'h00000070;
    tc(m, 1'b0);
    m.compareSelect = acl_pkg::L3_EXACT;
    m.ipv4Addr = h.srcIp;
    m.ipv4BitMask = h.dstIp;
    tc(m, 1'b1);
    m.compareSelect = 2'h0;
    tc(m, 1'b0);
    m.ruleMode = acl_pkg::MODE_L4;
    m.compareSelect = acl_pkg::L4_PROTO;
    m.ipProtocolValue = h.ipProtocol;
    tc(m, 1'b1);
    m.ipProtocolValue = ~h.ipProtocol;
    tc(m, 1'b0);
    m.compareSelect = acl_pkg::L4_TCP;
    m.portLower = h.dstPort;
    m.portUpper = h.dstPort;
    m.portCompareMode = acl_pkg::PC_IN;
    tc(m, 1'b1);
    m.portCompareMode = acl_pkg::PC_OUT;
    tc(m, 1'b0);
    m.portUpper = h.srcPort;
    m.portCompareMode = acl_pkg::PC_EITHER;
    tc(m, 1'b1);
    m.compareSelect = acl_pkg::L4_UDP;
    tc(m, 1'b0);
    m.compareSelect = acl_pkg::L4_SEQ;
    m.portCompareMode = 2'h0;
    {m.portUpper, m.portLower} = h.tcpSeq;
    m.tcpFlagMatchEnable = 1'b1;
    m.tcpFlagValue = h.tcpFlags ^ 8'h01;
    m.tcpFlagMask = 8'h01;
    tc(m, 1'b1);
    m.tcpFlagMask = 8'h00;
    tc(m, 1'b0);
    wr(4'h0, '0, '0, 20'h00001, 3'h4);
    m = '0;
    m.ruleMode = acl_pkg::MODE_L2;
    m.compareSelect = acl_pkg::L2_COUNT;
    m.equalitySense = 1'b1;
    m.macAddr = h.dstMac;
    m.etherType = h.etherType;
    a = '0;
    a.mapMode = 2'h2;
    a.counterAlgorithm = 1'b1;
    wr(4'h3, m, a, '0, 3'h6);
    send(h, {16'h0008, 5'h00});
    repeat (4) @(posedge clk_sys);
    check("irqEarly", 21'(irqStatus), 21'h0);
    send(h, {16'h0008, 5'h00});
    waitIrq(2, 2, 10);
    check("portIrq", 21'(portIrq), 21'h4);
    clr(6'h04);
    // Countdown of 3 us, re-armed midway so only a reload explains the late expiry
    h.ingressPort = 3'h1;
    a.mapMode = 2'h3;
    a.counterAlgorithm = 1'b0;
    wr(4'h3, m, a, '0, 3'h2);
    send(h, {16'h0008, 5'h00});
    repeat (30) @(posedge clk_sys);
    send(h, {16'h0008, 5'h00});
    waitIrq(1, 40, 66);
    check("portIrqMasked", 21'(portIrq), 21'h0);
    clr(6'h02);
    a.mapMode = 2'h2;
    a.timeUnit = 1'b1;
    wr(4'h3, m, a, '0, 3'h2);
    send(h, {16'h0008, 5'h00});
    waitIrq(1, 19990, 40010);
    m.compareSelect = acl_pkg::L2_MAC;
    wr(4'h1, m, '0, {4'h7, 16'h000A}, 3'h5);
    m.macAddr = h.srcMac;
    wr(4'h2, m, '0, {4'h4, 16'h0002}, 3'h5);
    wr(4'h0, '0, '0, {4'h1, 16'h0006}, 3'h1);
    // Distinct pattern in the winning action entry
    a.priorityValue = 3'h5;
    a.forwardMap = 6'h15;
    wr(4'h4, '0, a, '0, 3'h2);
    expAct = a;
    send(h, {16'h000A, 1'b1, 4'h4});
    repeat (4) @(posedge clk_sys);
    check("pending", 21'(expQ.size()), 21'h0);
    finish_test();
  end
endmodule : acl_matching_rule_evaluator_test

// file: verification/acl_rule_checker_sva.sv
// Checker: result timing and interrupt status properties at the ports
`timescale 1ns/1ns
module acl_rule_checker (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // Header and result
  input wire acl_pkg::frame_hdr_t hdr,
  input wire acl_pkg::acl_result_t result,
  // Interrupts
  input wire logic [acl_pkg::NUM_PORTS-1:0] irqMask,
  input wire logic [acl_pkg::NUM_PORTS-1:0] irqClear,
  input wire logic [acl_pkg::NUM_PORTS-1:0] irqStatus,
  input wire logic [acl_pkg::NUM_PORTS-1:0] portIrq
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  AST_RESULT_NEXT: assert property (hdr.valid |=> result.valid)
    else $error("no result after header");
  AST_RESULT_IDLE: assert property (!hdr.valid |=> !result.valid)
    else $error("result without header");
  AST_HIT_VALID: assert property (result.hit |-> result.valid)
    else $error("hit outside result");
  AST_HIT_ENTRIES: assert property (result.hit |-> result.entryHits != '0)
    else $error("hit with no entry hit");
  AST_MISS_INDEX: assert property (
    result.valid && !result.hit |-> result.actionIndex == 4'h0)
    else $error("miss with nonzero index");
  AST_IRQ_MASK: assert property ((portIrq & ~$past(irqMask)) == 6'h00)
    else $error("masked port interrupt");
  AST_IRQ_STATUS: assert property ((portIrq & ~irqStatus) == 6'h00)
    else $error("port interrupt without status");
  AST_IRQ_STICKY: assert property (
    (~irqStatus & $past(irqStatus) & ~$past(irqClear)) == 6'h00)
    else $error("status dropped without clear");
endmodule : acl_rule_checker

bind acl_matching_rule_evaluator acl_rule_checker chk (.clk_sys(clk_sys), .rst_b(rst_b),
  .hdr(hdr), .result(result), .irqMask(irqMask), .irqClear(irqClear),
  .irqStatus(irqStatus), .portIrq(portIrq));
